// file: pxs_pkg.sv
// pxs_pkg: constants and state types for the proximity sensor register block
// assumes a 200 MHz ref_clk and a host that uses word transfers only
package pxs_pkg;

	// bus address and command codes
	localparam logic [6:0] SLAVE_ADDR    = 7'h60;
	localparam logic [7:0] CMD_RSV0      = 8'h00;
	localparam logic [7:0] CMD_CONF12    = 8'h03;
	localparam logic [7:0] CMD_CONF3MS   = 8'h04;
	localparam logic [7:0] CMD_CANCEL    = 8'h05;
	localparam logic [7:0] CMD_LOW_THR   = 8'h06;
	localparam logic [7:0] CMD_HIGH_THR  = 8'h07;
	localparam logic [7:0] CMD_RESULT    = 8'h08;
	localparam logic [7:0] CMD_FLAGS     = 8'h0b;
	localparam logic [7:0] CMD_IDENT     = 8'h0c;

	// reset values
	localparam logic [7:0]  CONF1_RST    = 8'h03;
	localparam logic [7:0]  BYTE_RST     = 8'h00;
	localparam logic [15:0] WORD_RST     = 16'h0000;
	localparam logic [7:0]  RSV0_LOW_VAL = 8'h01;
	// identification bytes: values are arbitrary
	localparam logic [7:0]  IDENT_LOW    = 8'h3c;
	localparam logic [7:0]  IDENT_HIGH   = 8'h07;

	// field positions
	localparam int SHUTDOWN_BIT   = 0;
	localparam int PERS_LSB       = 4;
	localparam int HIRES_BIT      = 3;
	localparam int FORCE_BIT      = 3;
	localparam int TRIG_BIT       = 2;
	localparam int SMART_BIT      = 4;
	localparam int LOGIC_MODE_BIT = 0;
	localparam int IRQ_CLOSE_MODE = 0;
	localparam int IRQ_AWAY_MODE  = 1;
	localparam int FLAG_AWAY_BIT  = 0;
	localparam int FLAG_CLOSE_BIT = 1;
	localparam logic [15:0] RES12_MAX = 16'h0fff;

	// timing counts in ref_clk cycles
	localparam int MEAS_PERIOD_CYC = 2000;
	localparam int SMART_GAP_CYC   = 16;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_WDATA,
		ST_RDATA,
		ST_SKIP
	} pxs_bus_st_t;

endpackage

// file: pxs_sync3.sv
// pxs_sync3: three-flop synchroniser with agreement filter for a pin input
// assumes d is asynchronous to clk; q changes only once stages two and three agree
`timescale 1ns/1ps
module pxs_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and control
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic ce,
	// pin and filtered level
	input  wire logic d,
	output logic      q
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} pxs_sync_st_t;

	pxs_sync_st_t r_reg;
	pxs_sync_st_t r_next;

	always_comb
	begin
		r_next = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		if (r_reg.s2 == r_reg.s3)
		begin
			r_next.q = r_reg.s3;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			r_reg <= {4{RST_VAL}};
		end
		else if (ce)
		begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.q;

endmodule // pxs_sync3

// file: pxs_persist.sv
// pxs_persist: consecutive-sample counter for one threshold direction
// assumes sample is a one-cycle pulse from the same clock
`timescale 1ns/1ps
module pxs_persist (
	// clock and control
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       ce,
	// sample stream
	input  wire logic       sample,
	input  wire logic       beyond,
	input  wire logic [1:0] need,
	// result
	output logic            hit,
	output logic            pending
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       started;
		logic       hit;
	} pxs_pers_st_t;

	pxs_pers_st_t r_reg;
	pxs_pers_st_t r_next;

	always_comb
	begin
		r_next = r_reg;
		r_next.hit = 1'b0;
		if (sample && !beyond)
		begin
			r_next.cnt = 2'h0;
			r_next.started = 1'b0;
		end
		else if (sample && r_reg.started && r_reg.cnt == need)
		begin
			r_next.hit = 1'b1;
		end
		else if (sample && !r_reg.started && need == 2'h0)
		begin
			r_next.started = 1'b1;
			r_next.hit = 1'b1;
		end
		else if (sample)
		begin
			r_next.cnt = r_reg.started ? r_reg.cnt + 2'h1 : 2'h1;
			r_next.started = 1'b1;
			r_next.hit = (r_reg.started ? r_reg.cnt + 2'h1 : 2'h1) > need;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			r_reg <= '0;
		end
		else if (ce)
		begin
			r_reg <= r_next;
		end
	end

	assign hit = r_reg.hit;
	assign pending = r_reg.started && !r_reg.hit;

	default clocking pc @(posedge clk); endclocking
	default disable iff (reset);

	no_hit_inside_a: assert property ((ce && sample && !beyond) |=> !hit)
		else $error("hit raised on a sample inside the threshold");
	full_count_a: assert property ((ce && sample && beyond && need == 2'h0) |=> hit)
		else $error("single-sample persistence did not hit");

endmodule // pxs_persist

// file: pxs_regs.sv
// pxs_regs: bus slave, register bank and interrupt logic of the proximity sensor
// assumes scl and sda pins from a host bus master, measurement results from the
// analog front end as a one-cycle pulse on ref_clk, and external pull-ups
`timescale 1ns/1ps

// Notes on behaviour
// - answer only slave address 0x60
// - registers accessed by whole word transfers
// - acknowledge address, command and written bytes
// - reading flag register clears the interrupt
// - interrupt on crossing high or low threshold
// - persistence count gates the interrupt
// - logic output mode drives plain proximity level
// - config one resets to 0x03, rest zero
// - result readable, never writable, one command
// - thresholds writable as sixteen-bit words
// - cancellation level subtracted from measurement
// - flags tell close event from away event
// - config one holds duty, time, persistence, shutdown
// - smart persistence shortens confirmation delay
// - persistence code selects one to four samples
// - interrupt mode disables, close, away, both
// - shutdown bit one stops the sensor
// - forced trigger starts one measurement, self-clears
module pxs_regs #(
	parameter int MEAS_PERIOD_CYC = pxs_pkg::MEAS_PERIOD_CYC
) (
	// clock and control
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// serial bus pins
	input  wire logic        scl_in,
	input  wire logic        serial_data_pin_in,
	output logic             serial_data_pin_out,
	output logic             serial_data_pin_oe,
	// interrupt pin, open drain
	output logic             irq_pin_out,
	output logic             irq_pin_oe,
	// analog front end
	input  wire logic        meas_valid,
	input  wire logic [15:0] meas_raw,
	output logic             meas_start,
	output logic             sensor_on
);
	typedef struct packed {
		pxs_pkg::pxs_bus_st_t st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  tx;
		logic        hi;
		logic        wdone;
		logic [7:0]  cmd;
		logic [7:0]  wlo;
		logic        scl_d;
		logic        sda_d;
		logic        sda_oe;
		logic [7:0]  conf1;
		logic [7:0]  conf2;
		logic [7:0]  conf3;
		logic [7:0]  ms;
		logic [15:0] canc;
		logic [15:0] thdl;
		logic [15:0] thdh;
		logic [15:0] data;
		logic [1:0]  flags;
		logic        near;
		logic        smp;
		logic [31:0] tmr;
		logic        start;
		logic        on;
		logic        irq_oe;
	} pxs_regs_st_t;

	localparam logic [31:0] PERIOD_LAST = 32'(MEAS_PERIOD_CYC - 1);
	localparam logic [31:0] SMART_GAP   = 32'(pxs_pkg::SMART_GAP_CYC);

	pxs_regs_st_t r_reg;
	pxs_regs_st_t r_next;
	logic         scl_f;
	logic         sda_f;
	logic         hit_hi;
	logic         hit_lo;
	logic         pend_hi;
	logic         pend_lo;
	logic         rise;
	logic         fall;
	logic         bus_start;
	logic         bus_stop;
	logic         load_flags;
	logic         commit;
	logic         ev_close;
	logic         ev_away;
	logic [15:0]  rdw;
	logic [15:0]  canc_res;
	logic [7:0]   txb;

	pxs_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
		.clk   (ref_clk),
		.reset (reset),
		.ce    (ce),
		.d     (scl_in),
		.q     (scl_f)
	);

	pxs_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
		.clk   (ref_clk),
		.reset (reset),
		.ce    (ce),
		.d     (serial_data_pin_in),
		.q     (sda_f)
	);

	pxs_persist u_pers_hi (
		.clk     (ref_clk),
		.reset   (reset),
		.ce      (ce),
		.sample  (r_reg.smp),
		.beyond  (r_reg.data > r_reg.thdh),
		.need    (r_reg.conf1[pxs_pkg::PERS_LSB +: 2]),
		.hit     (hit_hi),
		.pending (pend_hi)
	);

	pxs_persist u_pers_lo (
		.clk     (ref_clk),
		.reset   (reset),
		.ce      (ce),
		.sample  (r_reg.smp),
		.beyond  (r_reg.data < r_reg.thdl),
		.need    (r_reg.conf1[pxs_pkg::PERS_LSB +: 2]),
		.hit     (hit_lo),
		.pending (pend_lo)
	);

	always_comb
	begin
		r_next = r_reg;
		r_next.scl_d = scl_f;
		r_next.sda_d = sda_f;
		r_next.start = 1'b0;
		r_next.smp = 1'b0;
		load_flags = 1'b0;
		commit = 1'b0;
		txb = 8'h00;
		rise = scl_f && !r_reg.scl_d;
		fall = !scl_f && r_reg.scl_d;
		bus_start = scl_f && r_reg.scl_d && r_reg.sda_d && !sda_f;
		bus_stop = scl_f && r_reg.scl_d && !r_reg.sda_d && sda_f;

		// read word for the latched command code, low byte first on the wire
		if (r_reg.cmd == pxs_pkg::CMD_RSV0)
			rdw = {pxs_pkg::BYTE_RST, pxs_pkg::RSV0_LOW_VAL};
		else if (r_reg.cmd == pxs_pkg::CMD_CONF12)
			rdw = {r_reg.conf2, r_reg.conf1};
		else if (r_reg.cmd == pxs_pkg::CMD_CONF3MS)
			rdw = {r_reg.ms, r_reg.conf3};
		else if (r_reg.cmd == pxs_pkg::CMD_CANCEL)
			rdw = r_reg.canc;
		else if (r_reg.cmd == pxs_pkg::CMD_LOW_THR)
			rdw = r_reg.thdl;
		else if (r_reg.cmd == pxs_pkg::CMD_HIGH_THR)
			rdw = r_reg.thdh;
		else if (r_reg.cmd == pxs_pkg::CMD_RESULT)
			rdw = r_reg.data;
		else if (r_reg.cmd == pxs_pkg::CMD_FLAGS)
			rdw = {6'h00, r_reg.flags, pxs_pkg::BYTE_RST};
		else if (r_reg.cmd == pxs_pkg::CMD_IDENT)
			rdw = {pxs_pkg::IDENT_HIGH, pxs_pkg::IDENT_LOW};
		else
			rdw = pxs_pkg::WORD_RST;

		// bus slave: bits shift in on scl rise, sda changes on scl fall
		if (bus_start)
		begin
			r_next.st = pxs_pkg::ST_ADDR;
			r_next.cnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end
		else if (bus_stop)
		begin
			r_next.st = pxs_pkg::ST_IDLE;
			r_next.sda_oe = 1'b0;
		end
		else if (r_reg.st != pxs_pkg::ST_IDLE && r_reg.st != pxs_pkg::ST_SKIP)
		begin
			if (rise && r_reg.cnt < 4'h8)
			begin
				r_next.sh = {r_reg.sh[6:0], sda_f};
				r_next.cnt = r_reg.cnt + 4'h1;
			end
			else if (rise && r_reg.cnt == 4'h8 && r_reg.st == pxs_pkg::ST_RDATA)
			begin
				// master nack ends the read
				if (sda_f)
					r_next.st = pxs_pkg::ST_SKIP;
				else
					r_next.cnt = 4'h9;
			end
			else if (fall && r_reg.cnt == 4'h8 && r_reg.st == pxs_pkg::ST_RDATA)
			begin
				r_next.sda_oe = 1'b0;
			end
			else if (fall && r_reg.cnt == 4'h8)
			begin
				r_next.cnt = 4'h9;
				r_next.sda_oe = 1'b1;
				case (r_reg.st)
					pxs_pkg::ST_ADDR:
					begin
						if (r_reg.sh[7:1] != pxs_pkg::SLAVE_ADDR)
						begin
							r_next.st = pxs_pkg::ST_SKIP;
							r_next.sda_oe = 1'b0;
						end
						else if (r_reg.sh[0])
						begin
							r_next.st = pxs_pkg::ST_RDATA;
							r_next.hi = 1'b0;
						end
						else
						begin
							r_next.st = pxs_pkg::ST_CMD;
						end
					end
					pxs_pkg::ST_CMD:
					begin
						r_next.cmd = r_reg.sh;
						r_next.st = pxs_pkg::ST_WDATA;
						r_next.hi = 1'b0;
						r_next.wdone = 1'b0;
					end
					pxs_pkg::ST_WDATA:
					begin
						if (r_reg.wdone)
						begin
							r_next.sda_oe = 1'b0;
						end
						else if (!r_reg.hi)
						begin
							r_next.wlo = r_reg.sh;
							r_next.hi = 1'b1;
						end
						else
						begin
							commit = 1'b1;
							r_next.wdone = 1'b1;
						end
					end
					default:
					begin
						r_next.sda_oe = 1'b0;
					end
				endcase
			end
			else if (fall && r_reg.cnt == 4'h9)
			begin
				r_next.cnt = 4'h0;
				r_next.sda_oe = 1'b0;
				if (r_reg.st == pxs_pkg::ST_RDATA)
				begin
					txb = r_reg.hi ? rdw[15:8] : rdw[7:0];
					r_next.tx = txb;
					r_next.sda_oe = !txb[7];
					r_next.hi = !r_reg.hi;
					load_flags = r_reg.hi && r_reg.cmd == pxs_pkg::CMD_FLAGS;
				end
				else if (r_reg.st == pxs_pkg::ST_WDATA && r_reg.wdone)
				begin
					r_next.st = pxs_pkg::ST_SKIP;
				end
			end
			else if (fall && r_reg.st == pxs_pkg::ST_RDATA && r_reg.cnt != 4'h0)
			begin
				r_next.sda_oe = !r_reg.tx[3'h7 - r_reg.cnt[2:0]];
			end
		end

		// measurement scheduling: period timer, forced trigger, smart shortcut
		r_next.on = !r_reg.conf1[pxs_pkg::SHUTDOWN_BIT];
		if (r_reg.conf1[pxs_pkg::SHUTDOWN_BIT])
		begin
			r_next.tmr = PERIOD_LAST;
		end
		else if (r_reg.conf3[pxs_pkg::FORCE_BIT])
		begin
			if (r_reg.conf3[pxs_pkg::TRIG_BIT])
			begin
				r_next.start = 1'b1;
				r_next.conf3[pxs_pkg::TRIG_BIT] = 1'b0;
			end
		end
		else if (r_reg.tmr == 32'h0)
		begin
			r_next.start = 1'b1;
			r_next.tmr = PERIOD_LAST;
		end
		else if (r_reg.conf3[pxs_pkg::SMART_BIT] && (pend_hi || pend_lo) && r_reg.tmr > SMART_GAP)
		begin
			r_next.tmr = SMART_GAP;
		end
		else
		begin
			r_next.tmr = r_reg.tmr - 32'h1;
		end

		// cancellation and resolution
		canc_res = (meas_raw > r_reg.canc) ? meas_raw - r_reg.canc : 16'h0000;
		if (!r_reg.conf2[pxs_pkg::HIRES_BIT] && canc_res > pxs_pkg::RES12_MAX)
			canc_res = pxs_pkg::RES12_MAX;
		if (meas_valid)
		begin
			r_next.data = canc_res;
			r_next.smp = 1'b1;
		end

		// threshold events with hysteresis on the near state
		ev_close = hit_hi && !r_reg.near;
		ev_away = hit_lo && r_reg.near;
		if (ev_close)
			r_next.near = 1'b1;
		else if (ev_away)
			r_next.near = 1'b0;
		if (load_flags)
			r_next.flags = 2'h0;
		if (ev_close && r_reg.conf2[pxs_pkg::IRQ_CLOSE_MODE])
			r_next.flags[pxs_pkg::FLAG_CLOSE_BIT] = 1'b1;
		if (ev_away && r_reg.conf2[pxs_pkg::IRQ_AWAY_MODE])
			r_next.flags[pxs_pkg::FLAG_AWAY_BIT] = 1'b1;
		if (r_reg.ms[pxs_pkg::LOGIC_MODE_BIT])
			r_next.irq_oe = r_reg.near;
		else
			r_next.irq_oe = |r_reg.flags;

		// register writes, whole words only
		if (commit)
		begin
			if (r_reg.cmd == pxs_pkg::CMD_CONF12)
			begin
				r_next.conf1 = r_reg.wlo;
				r_next.conf2 = r_reg.sh;
			end
			else if (r_reg.cmd == pxs_pkg::CMD_CONF3MS)
			begin
				r_next.conf3 = r_reg.wlo;
				r_next.ms = r_reg.sh;
			end
			else if (r_reg.cmd == pxs_pkg::CMD_CANCEL)
				r_next.canc = {r_reg.sh, r_reg.wlo};
			else if (r_reg.cmd == pxs_pkg::CMD_LOW_THR)
				r_next.thdl = {r_reg.sh, r_reg.wlo};
			else if (r_reg.cmd == pxs_pkg::CMD_HIGH_THR)
				r_next.thdh = {r_reg.sh, r_reg.wlo};
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			r_reg <= '0;
			r_reg.st <= pxs_pkg::ST_IDLE;
			r_reg.scl_d <= 1'b1;
			r_reg.sda_d <= 1'b1;
			r_reg.conf1 <= pxs_pkg::CONF1_RST;
			r_reg.tmr <= PERIOD_LAST;
		end
		else if (ce)
		begin
			r_reg <= r_next;
		end
	end

	assign serial_data_pin_out = 1'b0;
	assign serial_data_pin_oe = r_reg.sda_oe;
	assign irq_pin_out = 1'b0;
	assign irq_pin_oe = r_reg.irq_oe;
	assign meas_start = r_reg.start;
	assign sensor_on = r_reg.on;

	default clocking rc @(posedge ref_clk); endclocking
	default disable iff (reset);

	addr_mismatch_a: assert property ((ce && fall && !bus_start && !bus_stop && r_reg.st == pxs_pkg::ST_ADDR && r_reg.cnt == 4'h8 && r_reg.sh[7:1] != pxs_pkg::SLAVE_ADDR) |=> (r_reg.st == pxs_pkg::ST_SKIP && !serial_data_pin_oe))
		else $error("foreign address was not ignored");
	byte_ack_a: assert property ((ce && fall && !bus_start && !bus_stop && r_reg.cnt == 4'h8 && (r_reg.st == pxs_pkg::ST_CMD || (r_reg.st == pxs_pkg::ST_WDATA && !r_reg.wdone))) |=> serial_data_pin_oe)
		else $error("command or data byte not acknowledged");
	flag_clear_a: assert property ((ce && load_flags && !ev_close && !ev_away) |=> r_reg.flags == 2'h0 ##1 (!ce || r_reg.ms[pxs_pkg::LOGIC_MODE_BIT] || !irq_pin_oe))
		else $error("flag read did not release the interrupt");
	close_flag_a: assert property ((ce && ev_close && r_reg.conf2[pxs_pkg::IRQ_CLOSE_MODE]) |=> r_reg.flags[pxs_pkg::FLAG_CLOSE_BIT] ##1 (!ce || r_reg.ms[pxs_pkg::LOGIC_MODE_BIT] || irq_pin_oe))
		else $error("close event did not raise the interrupt");
	logic_mode_a: assert property ((ce && r_reg.ms[pxs_pkg::LOGIC_MODE_BIT]) |=> irq_pin_oe == $past(r_reg.near))
		else $error("logic output mode does not follow proximity");
	reset_value_a: assert property (@(posedge ref_clk) disable iff (1'b0) reset |=> (r_reg.conf1 == pxs_pkg::CONF1_RST && r_reg.flags == 2'h0 && r_reg.data == 16'h0000))
		else $error("register reset value wrong");
	result_ro_a: assert property ((ce && commit && r_reg.cmd == pxs_pkg::CMD_RESULT && !meas_valid) |=> $stable(r_reg.data))
		else $error("result register was written");
	cancel_floor_a: assert property ((ce && meas_valid && meas_raw <= r_reg.canc) |=> r_reg.data == 16'h0000)
		else $error("cancellation not applied");
	force_once_a: assert property ((ce && r_reg.on && !r_reg.conf1[pxs_pkg::SHUTDOWN_BIT] && r_reg.conf3[pxs_pkg::FORCE_BIT] && r_reg.conf3[pxs_pkg::TRIG_BIT] && !commit) |=> (meas_start && !r_reg.conf3[pxs_pkg::TRIG_BIT]) ##1 (!ce || !meas_start))
		else $error("forced trigger did not give exactly one start");

	read_flags_c: cover property (ce && load_flags && r_reg.flags != 2'h0);
	forced_meas_c: cover property (ce && r_reg.conf3[pxs_pkg::FORCE_BIT] && meas_start);
	close_event_c: cover property (ce && ev_close ##[1:1000] ev_away);

endmodule // pxs_regs

// file: pxs_host.sv
// pxs_host: bus master model standing in for the host controller
// assumes an open-drain data wire resolved with a pull-up by the testbench
`timescale 1ns/1ps
module pxs_host #(
	parameter int Q = 8
) (
	// clock
	input  wire logic ref_clk,
	// bus pins
	output logic      scl,
	output logic      sda_oe,
	input  wire logic sda
);
	initial
	begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	task automatic tq(input int n);
		repeat (n * Q) @(negedge ref_clk);
	endtask

	// start from idle, or repeated start with clock low
	task automatic start_c();
		sda_oe = 1'b0;
		tq(1);
		scl = 1'b1;
		tq(1);
		sda_oe = 1'b1;
		tq(1);
		scl = 1'b0;
		tq(1);
	endtask

	task automatic stop_c();
		sda_oe = 1'b1;
		tq(1);
		scl = 1'b1;
		tq(1);
		sda_oe = 1'b0;
		tq(2);
	endtask

	// data changes only while the clock is low
	task automatic bit_c(input logic b, output logic r);
		sda_oe = ~b;
		tq(1);
		scl = 1'b1;
		tq(1);
		r = sda;
		tq(1);
		scl = 1'b0;
		tq(1);
	endtask

	task automatic byte_tx(input logic [7:0] d, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_c(d[i], r);
		bit_c(1'b1, nack);
	endtask

	task automatic byte_rx(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_c(1'b1, d[i]);
		bit_c(last, r);
	endtask

	// whole word, low byte first; nothing more after an address refusal
	task automatic wr_word(input logic [6:0] a, input logic [7:0] cmd,
		input logic [15:0] w, output logic [3:0] nk);
		nk = 4'hf;
		start_c();
		byte_tx({a, 1'b0}, nk[3]);
		if (!nk[3])
		begin
			byte_tx(cmd, nk[2]);
			byte_tx(w[7:0], nk[1]);
			byte_tx(w[15:8], nk[0]);
		end
		stop_c();
	endtask

	task automatic rd_word(input logic [6:0] a, input logic [7:0] cmd,
		output logic [15:0] w, output logic [2:0] nk);
		start_c();
		byte_tx({a, 1'b0}, nk[2]);
		byte_tx(cmd, nk[1]);
		start_c();
		byte_tx({a, 1'b1}, nk[0]);
		byte_rx(w[7:0], 1'b0);
		byte_rx(w[15:8], 1'b1);
		stop_c();
	endtask
endmodule // pxs_host

// file: testbench.sv
// testbench: register and interrupt checks of pxs_regs through its serial bus
// assumes pxs_host as bus master and a bench-driven front end pulse
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
	logic        ref_clk;
	logic        reset;
	logic        ce;
	logic        scl;
	logic        host_oe;
	logic        sda;
	logic        dut_out;
	logic        dut_oe;
	logic        irq_out;
	logic        irq_oe;
	logic        irq_n;
	logic        meas_valid;
	logic [15:0] meas_raw;
	logic        meas_start;
	logic        sensor_on;
	logic [3:0]  nk;
	logic [2:0]  rk;
	logic [15:0] rd;
	logic [1:0]  pc;
	int          fails;
	int          n_checks;
	int          n_start;
	localparam logic [7:0]  RC [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h0c};
	localparam logic [15:0] RV [8] = '{16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, {pxs_pkg::IDENT_HIGH, pxs_pkg::IDENT_LOW}};

	assign sda = ~host_oe & (dut_oe ? dut_out : 1'b1);
	assign irq_n = irq_oe ? irq_out : 1'b1;

	always #2.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
		if (meas_start === 1'b1)
			n_start++;

	pxs_host i_host (
		.ref_clk (ref_clk),
		.scl     (scl),
		.sda_oe  (host_oe),
		.sda     (sda)
	);

	pxs_regs #(
		.MEAS_PERIOD_CYC(50)
	) i_dut (
		.ref_clk             (ref_clk),
		.reset               (reset),
		.ce                  (ce),
		.scl_in              (scl),
		.serial_data_pin_in  (sda),
		.serial_data_pin_out (dut_out),
		.serial_data_pin_oe  (dut_oe),
		.irq_pin_out         (irq_out),
		.irq_pin_oe          (irq_oe),
		.meas_valid          (meas_valid),
		.meas_raw            (meas_raw),
		.meas_start          (meas_start),
		.sensor_on           (sensor_on)
	);

	task automatic wrc(input logic [7:0] cmd, input logic [15:0] w);
		i_host.wr_word(pxs_pkg::SLAVE_ADDR, cmd, w, nk);
		`CHK("write acks", 4'h0, nk)
	endtask

	task automatic rdc(input logic [7:0] cmd, input logic [15:0] e);
		i_host.rd_word(pxs_pkg::SLAVE_ADDR, cmd, rd, rk);
		`CHK("read acks", 3'h0, rk)
		`CHK("read word", e, rd)
	endtask

	// one front end result, then the interrupt pin level
	task automatic smp(input logic [15:0] raw, input logic exp_n);
		meas_raw = raw;
		meas_valid = 1'b1;
		@(negedge ref_clk);
		meas_valid = 1'b0;
		repeat (20) @(negedge ref_clk);
		`CHK("irq_n", exp_n, irq_n)
	endtask

	task automatic done_t(input string s);
		$display("test done: %s", s);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (95000) @(posedge ref_clk);
		fails++;
		$display("ERROR watchdog expected finish seen hang");
		results();
	end

	initial
	begin
		ref_clk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		meas_valid = 1'b0;
		meas_raw = 16'h0000;
		fails = 0;
		n_checks = 0;
		n_start = 0;
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		repeat (10) @(negedge ref_clk);
		`CHK("sensor_on", 1'b0, sensor_on)
		`CHK("irq_n", 1'b1, irq_n)
		for (int i = 0; i < 8; i++)
			rdc(RC[i], RV[i]);
		done_t("reset values");

		wrc(pxs_pkg::CMD_CANCEL, 16'h0010);
		wrc(pxs_pkg::CMD_LOW_THR, 16'h0100);
		wrc(pxs_pkg::CMD_HIGH_THR, 16'h0200);
		i_host.wr_word(7'h61, pxs_pkg::CMD_LOW_THR, 16'hffff, nk);
		`CHK("foreign address acks", 4'hf, nk)
		wrc(pxs_pkg::CMD_RESULT, 16'hffff);
		rdc(pxs_pkg::CMD_CANCEL, 16'h0010);
		rdc(pxs_pkg::CMD_LOW_THR, 16'h0100);
		rdc(pxs_pkg::CMD_HIGH_THR, 16'h0200);
		rdc(pxs_pkg::CMD_RESULT, 16'h0000);
		// a front end result while frozen must not land
		ce = 1'b0;
		smp(16'h0310, 1'b1);
		ce = 1'b1;
		rdc(pxs_pkg::CMD_RESULT, 16'h0000);
		// 12-bit mode saturates after cancellation
		smp(16'hffff, 1'b1);
		rdc(pxs_pkg::CMD_RESULT, 16'h0fff);
		done_t("register access");

		wrc(pxs_pkg::CMD_CONF12, 16'h0800);
		`CHK("sensor_on", 1'b1, sensor_on)
		n_start = 0;
		repeat (500) @(negedge ref_clk);
		`CHK("periodic starts", 10, n_start)
		done_t("power on");

		// persistence code and interrupt mode share one 2-bit loop value
		for (int p = 0; p < 4; p++)
		begin
			pc = p[1:0];
			wrc(pxs_pkg::CMD_CONF12, {6'h02, pc, 2'b00, pc, 4'h0});
			repeat (p) smp(16'h0310, 1'b1);
			smp(16'h0310, ~pc[0]);
			repeat (100) @(negedge ref_clk);
			`CHK("irq held", ~pc[0], irq_n)
			rdc(pxs_pkg::CMD_FLAGS, {6'h00, pc[0], 9'h000});
			`CHK("irq cleared", 1'b1, irq_n)
			repeat (p) smp(16'h0020, 1'b1);
			smp(16'h0020, ~pc[1]);
			rdc(pxs_pkg::CMD_FLAGS, {7'h00, pc[1], 8'h00});
			`CHK("irq cleared", 1'b1, irq_n)
			done_t("persistence and modes");
		end
		rdc(pxs_pkg::CMD_RESULT, 16'h0010);
		// raw below the cancellation level floors at zero
		smp(16'h0008, 1'b1);
		rdc(pxs_pkg::CMD_RESULT, 16'h0000);
		// a count in progress cuts the period to the smart gap
		wrc(pxs_pkg::CMD_CONF3MS, 16'h0010);
		smp(16'h0310, 1'b1);
		n_start = 0;
		repeat (80) @(negedge ref_clk);
		`CHK("smart starts", 1'b1, n_start >= 4)
		done_t("cancellation and smart persistence");

		wrc(pxs_pkg::CMD_CONF12, 16'h0b00);
		wrc(pxs_pkg::CMD_CONF3MS, 16'h0100);
		smp(16'h0310, 1'b0);
		smp(16'h0020, 1'b1);
		done_t("logic output");

		wrc(pxs_pkg::CMD_CONF3MS, 16'h0008);
		repeat (100) @(negedge ref_clk);
		n_start = 0;
		wrc(pxs_pkg::CMD_CONF3MS, 16'h000c);
		repeat (100) @(negedge ref_clk);
		`CHK("forced starts", 1, n_start)
		rdc(pxs_pkg::CMD_CONF3MS, 16'h0008);
		done_t("forced trigger");
		results();
	end
endmodule // testbench
